/* rtl/sfqr_pkg.sv */
// Constants, types and small decode helpers for the flash command block.
// Assumes a 25 MHz system clock that oversamples the serial clock pin.
//
// Contract
// - In quad mode the read-parameter command sets dummy count and wrap length.
// - Dummy select 00 gives 4 clocks, 01 gives 6, 10 and 11 give 8.
// - Wrap select 00/01/10/11 gives 8/16/32/64 byte wrap.
// - In SPI mode wrap length comes from the set-burst-with-wrap command.
// - Wrap length set in SPI mode survives entry into quad mode.
// - Quad wrap read is fast read whose address wraps in its aligned window.
// - Enable-quad enters quad mode only when quad_io_permit is set.
// - Disable-quad returns the device to SPI operation.
// - Mode switches keep write latch, suspend state and wrap length.
// - Reset needs reset-enable in one frame, reset in the next, any mode.
// - Accepted reset aborts work and clears all volatile settings.
// - Reset takes about 60 us and every command is rejected meanwhile.
// - Discoverable-parameter read returns bytes of the parameter tables; the code holds only the signature and header bytes below 18H, FFH elsewhere.
// - Header gives revision 1.0, header count 01H, unused bytes FFH.
// - First header: ID 00H, rev 1.0, length 09H, pointer 000030H.
// - Second header: maker code, rev 1.0, length 03H, pointer 000060H.
package sfqr_pkg;
  localparam logic [7:0] OP_READ_PARAM  = 8'hC0;
  localparam logic [7:0] OP_FAST_READ   = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO_RD  = 8'hEB;
  localparam logic [7:0] OP_SET_WRAP    = 8'h77;
  localparam logic [7:0] OP_WRAP_READ   = 8'h0C;
  localparam logic [7:0] OP_QUAD_ENTER  = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT   = 8'hFF;
  localparam logic [7:0] OP_RST_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RST_DO      = 8'h99;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;

  localparam logic [5:0] OPCODE_BITS    = 6'd8;
  localparam logic [5:0] ADDR_BITS      = 6'd24;
  localparam logic [5:0] BYTE_BITS      = 6'd8;
  localparam logic [5:0] SET_WRAP_BITS  = 6'd32;
  localparam logic [5:0] TABLE_DUMMIES  = 6'd8;
  localparam logic [5:0] SPI_DUMMIES    = 6'd8;

  localparam int CLK_FREQ_MHZ  = 25;
  localparam int RESET_TIME_NS = 60000;
  localparam int RESET_CYCLES  = (RESET_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [10:0] RESET_LOAD = 11'(RESET_CYCLES - 1);

  localparam logic [7:0] SIG_B0 = 8'h53;
  localparam logic [7:0] SIG_B1 = 8'h46;
  localparam logic [7:0] SIG_B2 = 8'h44;
  localparam logic [7:0] SIG_B3 = 8'h50;
  localparam logic [7:0] REV_MINOR  = 8'h00;
  localparam logic [7:0] REV_MAJOR  = 8'h01;
  localparam logic [7:0] HDR_COUNT  = 8'h01;
  localparam logic [7:0] UNUSED_VAL = 8'hFF;
  localparam logic [7:0] STD_ID     = 8'h00;
  localparam logic [7:0] HDR0_LEN   = 8'h09;
  localparam logic [7:0] HDR0_PTR   = 8'h30;
  localparam logic [7:0] HDR1_LEN   = 8'h03;
  localparam logic [7:0] HDR1_PTR   = 8'h60;
  localparam logic [7:0] PTR_HIGH   = 8'h00;
  // Offsets of the table header words, in units of four bytes
  localparam logic [4:0] OFS_SIG    = 5'h00;
  localparam logic [4:0] OFS_REV    = 5'h01;
  localparam logic [4:0] OFS_HDR0   = 5'h02;
  localparam logic [4:0] OFS_HDR0P  = 5'h03;
  localparam logic [4:0] OFS_HDR1   = 5'h04;
  localparam logic [4:0] OFS_HDR1P  = 5'h05;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR   = 7'h04,
    ST_ARG    = 7'h08,
    ST_DUMMY  = 7'h10,
    ST_DATA   = 7'h20,
    ST_IGNORE = 7'h40
  } state_t;

  function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
    case (sel)
      2'h0:    dummy_clocks = 4'h4;
      2'h1:    dummy_clocks = 4'h6;
      default: dummy_clocks = 4'h8;
    endcase
  endfunction

  function automatic logic [6:0] wrap_bytes(input logic [1:0] sel);
    case (sel)
      2'h0:    wrap_bytes = 7'h08;
      2'h1:    wrap_bytes = 7'h10;
      2'h2:    wrap_bytes = 7'h20;
      default: wrap_bytes = 7'h40;
    endcase
  endfunction
endpackage

/* rtl/table_rd_if.sv */
// Read port between the command block and the parameter-table memory.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface table_rd_if;
  logic [7:0] addr;
  logic [7:0] data;
  modport reader (output addr, input data);
  modport store  (input addr, output data);
endinterface

/* rtl/param_table_rom.sv */
// Parameter-table memory: signature and two headers, read data registered.
// Assumes the reader holds the address at least one cycle before using data.
`timescale 1ns/1ps
module param_table_rom #(
  parameter logic [7:0] MAKER_CODE = 8'h5E  // Arbitrary value
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  table_rd_if.store  rd
);
  import sfqr_pkg::*;

  logic [7:0] next_data;
  logic [7:0] data;

  always_comb begin
    next_data = UNUSED_VAL;
    if (rd.addr[7:5] == 3'h0) begin
      case (rd.addr[4:2])
        OFS_SIG[2:0]: begin
          case (rd.addr[1:0])
            2'h0:    next_data = SIG_B0;
            2'h1:    next_data = SIG_B1;
            2'h2:    next_data = SIG_B2;
            default: next_data = SIG_B3;
          endcase
        end
        OFS_REV[2:0]: begin
          case (rd.addr[1:0])
            2'h0:    next_data = REV_MINOR;
            2'h1:    next_data = REV_MAJOR;
            2'h2:    next_data = HDR_COUNT;
            default: next_data = UNUSED_VAL;
          endcase
        end
        OFS_HDR0[2:0], OFS_HDR1[2:0]: begin
          case (rd.addr[1:0])
            2'h0:    next_data = rd.addr[4] ? MAKER_CODE : STD_ID;
            2'h1:    next_data = REV_MINOR;
            2'h2:    next_data = REV_MAJOR;
            default: next_data = rd.addr[4] ? HDR1_LEN : HDR0_LEN;
          endcase
        end
        OFS_HDR0P[2:0], OFS_HDR1P[2:0]: begin
          case (rd.addr[1:0])
            2'h0:    next_data = rd.addr[4] ? HDR1_PTR : HDR0_PTR;
            2'h3:    next_data = UNUSED_VAL;
            default: next_data = PTR_HIGH;
          endcase
        end
        default: next_data = UNUSED_VAL;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data <= UNUSED_VAL;
    end else begin
      data <= next_data;
    end
  end

  assign rd.data = data;

  a_sig_first: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && ($past(rd.addr) == 8'h00)) |-> (data == 8'h53))
    else $error("signature byte wrong");
  a_hdr_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && ($past(rd.addr) == 8'h06)) |-> (data == 8'h01))
    else $error("header count byte wrong");
  a_hdr0_ptr: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && ($past(rd.addr) == 8'h0C)) |-> (data == 8'h30))
    else $error("first table pointer wrong");
endmodule // param_table_rom

/* rtl/serial_flash_quad_mode_reset_ctrl.sv */
// Command front end of a serial flash: quad mode, read setup, reset, table reads.
// Assumes SPI mode 0 with each serial clock level lasting four i_clk cycles or more.
`timescale 1ns/1ps
module serial_flash_quad_mode_reset_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic [3:0]  i_io,
  output logic      [3:0]  o_io,
  output logic      [3:0]  o_io_oe,
  input  wire logic        i_quad_io_permit,
  input  wire logic        i_write_latch_set,
  input  wire logic        i_write_latch_clr,
  input  wire logic        i_suspend_set,
  input  wire logic        i_suspend_clr,
  input  wire logic [7:0]  i_array_data,
  output logic      [23:0] o_array_addr,
  output logic             o_quad_command_mode,
  output logic             o_write_latch_flag,
  output logic             o_suspend_flag,
  output logic      [7:0]  o_read_param_byte,
  output logic      [7:0]  o_continuous_read_bits,
  output logic      [2:0]  o_wrap_config_bits,
  output logic      [3:0]  o_dummy_clocks,
  output logic      [6:0]  o_wrap_bytes,
  output logic             o_reset_busy,
  output logic             o_abort
);
  import sfqr_pkg::*;

  // Pin sampling: three stages, a change counts once stages two and three agree
  logic [5:0] sync1, sync2, sync3, filt, filt_d;
  logic [5:0] next_filt;

  always_comb begin
    next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1  <= 6'h3F;
      sync2  <= 6'h3F;
      sync3  <= 6'h3F;
      filt   <= 6'h3F;
      filt_d <= 6'h3F;
    end else begin
      sync1  <= {i_cs_n, i_sclk, i_io};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  logic       cs_fall, cs_rise, clk_rise, clk_fall;
  logic [3:0] io_s;
  assign cs_fall  = filt_d[5] & ~filt[5];
  assign cs_rise  = ~filt_d[5] & filt[5];
  assign clk_rise = ~filt[5] & ~filt_d[4] & filt[4];
  assign clk_fall = ~filt[5] & filt_d[4] & ~filt[4];
  assign io_s     = filt[3:0];

  table_rd_if tbl ();
  param_table_rom u_rom (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .rd    (tbl.store)
  );

  state_t      state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic        op_done, next_op_done;
  logic [31:0] shreg, next_shreg;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [2:0]  out_cnt, next_out_cnt;
  logic [23:0] addr, next_addr;
  logic [3:0]  io_out, next_io_out;
  logic [3:0]  io_oe, next_io_oe;
  logic        quad, next_quad;
  logic        armed, next_armed;
  logic        wl, next_wl;
  logic        susp, next_susp;
  logic [7:0]  rpb, next_rpb;
  logic [7:0]  crb, next_crb;
  logic [2:0]  wcb, next_wcb;
  logic [1:0]  wrap_sel, next_wrap_sel;
  logic        busy, next_busy;
  logic [10:0] rst_cnt, next_rst_cnt;
  logic        abort, next_abort;

  logic [5:0]  lane_w, bits_now, dummy_target;
  logic [31:0] rx;
  logic [7:0]  src;
  logic [5:0]  wmask;
  logic        last_step;

  assign tbl.addr = addr[7:0];

  always_comb begin
    next_state    = state;
    next_cmd      = cmd;
    next_op_done  = op_done;
    next_shreg    = shreg;
    next_bit_cnt  = bit_cnt;
    next_out_cnt  = out_cnt;
    next_addr     = addr;
    next_io_out   = io_out;
    next_io_oe    = io_oe;
    next_quad     = quad;
    next_armed    = armed;
    next_wl       = wl;
    next_susp     = susp;
    next_rpb      = rpb;
    next_crb      = crb;
    next_wcb      = wcb;
    next_wrap_sel = wrap_sel;
    next_busy     = busy;
    next_rst_cnt  = rst_cnt;
    next_abort    = 1'b0;
    lane_w        = quad ? 6'd4 : 6'd1;
    bits_now      = bit_cnt + lane_w;
    rx            = quad ? {shreg[27:0], io_s} : {shreg[30:0], io_s[0]};
    dummy_target  = (cmd == OP_PARAM_TABLE) ? TABLE_DUMMIES :
                    (quad ? {2'b00, dummy_clocks(rpb[5:4])} : SPI_DUMMIES);
    src           = (cmd != OP_PARAM_TABLE) ? i_array_data :
                    ((addr[23:8] == 16'h0000) ? tbl.data : UNUSED_VAL);
    wmask         = 6'(wrap_bytes(wrap_sel) - 7'h01);
    last_step     = quad ? (out_cnt == 3'h1) : (out_cnt == 3'h7);

    // Mode switches never touch these two flags; set wins over clear
    if (i_write_latch_set) next_wl = 1'b1;
    else if (i_write_latch_clr) next_wl = 1'b0;
    if (i_suspend_set) next_susp = 1'b1;
    else if (i_suspend_clr) next_susp = 1'b0;

    if (busy) begin
      next_rst_cnt = rst_cnt - 11'h001;
      if (rst_cnt == 11'h000) next_busy = 1'b0;
    end

    if (cs_fall) begin
      next_state   = busy ? ST_IGNORE : ST_OPCODE;
      next_bit_cnt = 6'd0;
      next_op_done = 1'b0;
    end else if (cs_rise) begin
      next_state = ST_IDLE;
      next_io_oe = 4'h0;
      if (!busy) begin
        next_armed = op_done && (cmd == OP_RST_ENABLE);
        if (op_done && (cmd == OP_RST_DO) && armed) begin
          // Reset outranks any flag set in the same cycle
          next_busy     = 1'b1;
          next_rst_cnt  = RESET_LOAD;
          next_abort    = 1'b1;
          next_quad     = 1'b0;
          next_wl       = 1'b0;
          next_susp     = 1'b0;
          next_rpb      = 8'h00;
          next_crb      = 8'h00;
          next_wcb      = 3'h0;
          next_wrap_sel = 2'h0;
        end
      end
    end else if (clk_rise) begin
      case (state)
        ST_OPCODE: begin
          next_shreg   = rx;
          next_bit_cnt = bits_now;
          if (bits_now == OPCODE_BITS) begin
            next_cmd     = rx[7:0];
            next_op_done = 1'b1;
            next_bit_cnt = 6'd0;
            case (rx[7:0])
              OP_READ_PARAM:  next_state = quad ? ST_ARG : ST_IGNORE;
              OP_SET_WRAP:    next_state = quad ? ST_IGNORE : ST_ARG;
              OP_FAST_READ:   next_state = ST_ADDR;
              OP_WRAP_READ:   next_state = quad ? ST_ADDR : ST_IGNORE;
              OP_QUAD_IO_RD:  next_state = quad ? ST_ADDR : ST_IGNORE;
              OP_PARAM_TABLE: next_state = ST_ADDR;
              OP_QUAD_ENTER: begin
                next_state = ST_IGNORE;
                if (i_quad_io_permit) next_quad = 1'b1;
              end
              OP_QUAD_EXIT: begin
                next_state = ST_IGNORE;
                next_quad  = 1'b0;
              end
              default: next_state = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          next_shreg   = rx;
          next_bit_cnt = bits_now;
          if (bits_now == ADDR_BITS) begin
            next_addr    = rx[23:0];
            next_bit_cnt = 6'd0;
            next_state   = (cmd == OP_QUAD_IO_RD) ? ST_ARG : ST_DUMMY;
          end
        end
        ST_ARG: begin
          next_shreg   = rx;
          next_bit_cnt = bits_now;
          if (bits_now == ((cmd == OP_SET_WRAP) ? SET_WRAP_BITS : BYTE_BITS)) begin
            next_bit_cnt = 6'd0;
            next_state   = ST_IGNORE;
            if (cmd == OP_READ_PARAM) begin
              next_rpb      = rx[7:0];
              next_wrap_sel = rx[1:0];
            end else if (cmd == OP_SET_WRAP) begin
              next_wcb      = rx[6:4];
              next_wrap_sel = rx[6:5];
            end else begin
              next_crb   = rx[7:0];
              next_state = ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          next_bit_cnt = bit_cnt + 6'd1;
          if ((bit_cnt + 6'd1) == dummy_target) begin
            next_state   = ST_DATA;
            next_out_cnt = 3'h0;
          end
        end
        default: next_state = state;
      endcase
    end else if (clk_fall && (state == ST_DATA)) begin
      // Bytes stream out until select rises
      next_out_cnt = last_step ? 3'h0 : out_cnt + 3'h1;
      if (quad) begin
        next_io_out = out_cnt[0] ? src[3:0] : src[7:4];
        next_io_oe  = 4'hF;
      end else begin
        next_io_out = {2'b00, src[3'h7 - out_cnt], 1'b0};
        next_io_oe  = 4'h2;
      end
      if (last_step) begin
        if (cmd == OP_WRAP_READ) begin
          next_addr = {addr[23:6], (addr[5:0] & ~wmask) | ((addr[5:0] + 6'h01) & wmask)};
        end else begin
          next_addr = addr + 24'h000001;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      cmd      <= 8'h00;
      op_done  <= 1'b0;
      shreg    <= 32'h0000_0000;
      bit_cnt  <= 6'd0;
      out_cnt  <= 3'h0;
      addr     <= 24'h000000;
      io_out   <= 4'h0;
      io_oe    <= 4'h0;
      quad     <= 1'b0;
      armed    <= 1'b0;
      wl       <= 1'b0;
      susp     <= 1'b0;
      rpb      <= 8'h00;
      crb      <= 8'h00;
      wcb      <= 3'h0;
      wrap_sel <= 2'h0;
      busy     <= 1'b0;
      rst_cnt  <= 11'h000;
      abort    <= 1'b0;
    end else begin
      state    <= next_state;
      cmd      <= next_cmd;
      op_done  <= next_op_done;
      shreg    <= next_shreg;
      bit_cnt  <= next_bit_cnt;
      out_cnt  <= next_out_cnt;
      addr     <= next_addr;
      io_out   <= next_io_out;
      io_oe    <= next_io_oe;
      quad     <= next_quad;
      armed    <= next_armed;
      wl       <= next_wl;
      susp     <= next_susp;
      rpb      <= next_rpb;
      crb      <= next_crb;
      wcb      <= next_wcb;
      wrap_sel <= next_wrap_sel;
      busy     <= next_busy;
      rst_cnt  <= next_rst_cnt;
      abort    <= next_abort;
    end
  end

  assign o_io                   = io_out;
  assign o_io_oe                = io_oe;
  assign o_array_addr           = addr;
  assign o_quad_command_mode    = quad;
  assign o_write_latch_flag     = wl;
  assign o_suspend_flag         = susp;
  assign o_read_param_byte      = rpb;
  assign o_continuous_read_bits = crb;
  assign o_wrap_config_bits     = wcb;
  assign o_dummy_clocks         = dummy_clocks(rpb[5:4]);
  assign o_wrap_bytes           = wrap_bytes(wrap_sel);
  assign o_reset_busy           = busy;
  assign o_abort                = abort;

  // Helper: length of the reset-busy window
  logic [11:0] busy_len;
  always_ff @(posedge i_clk) begin
    if (i_rst || !busy) busy_len <= 12'h000;
    else busy_len <= busy_len + 12'h001;
  end

  a_dummy_map: assert property (@(posedge i_clk) disable iff (i_rst)
    o_dummy_clocks == ((rpb[5:4] == 2'h0) ? 4'h4 : ((rpb[5:4] == 2'h1) ? 4'h6 : 4'h8)))
    else $error("dummy clock mapping wrong");
  a_wrap_map: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wrap_bytes == (7'h08 << wrap_sel))
    else $error("wrap length mapping wrong");
  a_quad_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(quad) |-> $past(i_quad_io_permit) && ($past(state) == ST_OPCODE))
    else $error("quad mode entered without permit");
  a_mode_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
    ($changed(quad) && !$rose(busy)) |-> $stable(wrap_sel) && $stable(wcb))
    else $error("mode switch changed wrap setting");
  a_reset_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(busy) |-> !quad && !wl && !susp && (rpb == 8'h00) && (crb == 8'h00) && abort)
    else $error("reset left volatile state");
  a_busy_len: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(busy) |-> ($past(busy_len) == 12'd1499))
    else $error("reset busy window has wrong length");
  a_busy_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    (busy && $past(busy)) |-> (state inside {ST_IDLE, ST_IGNORE}) && (io_oe == 4'h0))
    else $error("command taken during reset");
  a_wrap_window: assert property (@(posedge i_clk) disable iff (i_rst)
    ($changed(addr) && (state == ST_DATA) && (cmd == OP_WRAP_READ))
      |-> ((addr[23:6] == $past(addr[23:6])) && ((addr[5:0] & ~wmask) == ($past(addr[5:0]) & ~wmask))))
    else $error("wrap read left its window");
  a_reset_pair: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(busy) |-> $past(armed) && ($past(cmd) == OP_RST_DO))
    else $error("reset without enable frame");
  a_oe_frame: assert property (@(posedge i_clk) disable iff (i_rst)
    (io_oe != 4'h0) |-> (state == ST_DATA) || cs_rise)
    else $error("data lines driven outside a read");
endmodule // serial_flash_quad_mode_reset_ctrl

/* test/spi_host_model.sv */
// Host controller model: opens and closes frames, shifts bits on the pins.
// Assumes the bench resolves the data lines from the device's output enables.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_io,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic      [3:0] o_io
);
  localparam int HALF = 4;  // Clock level length, 320 ns period, at the pin filter minimum
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'hF;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Serial clock parked low between frames
  task automatic frame(input logic open);
    wt(HALF);
    o_cs_n = !open;
    wt(open ? HALF : 3 * HALF);
  endtask
  // Released lines toggle every clock so a stale level never reads as data
  task automatic xfer(input logic [31:0] d, input int n, input logic q, input logic rd,
                      output logic [31:0] r);
    int w;
    w = q ? 4 : 1;
    r = '0;
    for (int i = n - w; i >= 0; i -= w) begin
      if (rd) o_io = ~o_io;
      else if (q) o_io = d[i +: 4];
      else o_io = {3'b111, d[i]};
      wt(HALF);
      o_sclk = 1'b1;
      wt(HALF - 1);
      r = q ? {r[27:0], i_io} : {r[30:0], i_io[1]};
      wt(1);
      o_sclk = 1'b0;
    end
  endtask
endmodule // spi_host_model

/* test/serial_flash_quad_mode_reset_ctrl_tb.sv */
// Bench for the flash command block: table, wrap, quad mode, reset.
// Assumes the host model drives the pins; array data follows the address.
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module serial_flash_quad_mode_reset_ctrl_tb;
  import sfqr_pkg::*;
  localparam logic [7:0] MAKER = 8'h5E;  // Arbitrary, the table default
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        cs_n, sclk, permit, wl_set, su_set, quad, wlf, suf, busy, abort;
  logic [3:0]  host_io, dev_io, dev_oe, io_wire, dck;
  logic [7:0]  arr_data, rpb, crb, p, w;
  logic [23:0] arr_addr, a;
  logic [2:0]  wcb;
  logic [6:0]  wby;
  logic [31:0] r;
  int          seed, k, n_errors, n_compared, n_abort, n_busy;
  always #20 i_clk = ~i_clk;
  assign io_wire = (dev_oe & dev_io) | (~dev_oe & host_io);
  always @(posedge i_clk) begin
    #1;
    arr_data = arr_addr[7:0] ^ 8'hA5;
  end
  always @(posedge i_clk) begin
    if (abort === 1'b1) n_abort++;
    if (busy === 1'b1) n_busy++;
  end
  spi_host_model u_spi_host_model (.i_clk(i_clk), .i_io(io_wire), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_io(host_io));
  serial_flash_quad_mode_reset_ctrl u_serial_flash_quad_mode_reset_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_io(io_wire),
    .o_io(dev_io), .o_io_oe(dev_oe), .i_quad_io_permit(permit),
    .i_write_latch_set(wl_set), .i_write_latch_clr(1'b0), .i_suspend_set(su_set),
    .i_suspend_clr(1'b0), .i_array_data(arr_data), .o_array_addr(arr_addr),
    .o_quad_command_mode(quad), .o_write_latch_flag(wlf), .o_suspend_flag(suf),
    .o_read_param_byte(rpb), .o_continuous_read_bits(crb), .o_wrap_config_bits(wcb),
    .o_dummy_clocks(dck), .o_wrap_bytes(wby), .o_reset_busy(busy), .o_abort(abort));
  function automatic logic [7:0] tbl(input logic [7:0] ad);
    case (ad)
      8'h00: tbl = 8'h53;
      8'h01: tbl = 8'h46;
      8'h02: tbl = 8'h44;
      8'h03: tbl = 8'h50;
      8'h05, 8'h06, 8'h0A, 8'h12: tbl = 8'h01;
      8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16: tbl = 8'h00;
      8'h0B: tbl = 8'h09;
      8'h0C: tbl = 8'h30;
      8'h10: tbl = MAKER;
      8'h13: tbl = 8'h03;
      8'h14: tbl = 8'h60;
      default: tbl = 8'hFF;
    endcase
  endfunction
  function automatic logic [6:0] wrap_of(input logic [1:0] s);
    wrap_of = 7'h08 << s;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic fr(input logic open);
    u_spi_host_model.frame(open);
  endtask
  task automatic tx(input logic [31:0] d, input int n, input logic q, input logic rd);
    u_spi_host_model.xfer(d, n, q, rd, r);
  endtask
  task automatic op(input logic [7:0] c, input logic q);
    fr(1'b1);
    tx({24'h0, c}, 8, q, 1'b0);
    fr(1'b0);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    seed = 27;
    {permit, wl_set, su_set, arr_data} = '0;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    `CHK("reset_state", 0, {quad, wlf, suf, rpb, crb, wcb, busy});
    fr(1'b1);
    tx({OP_PARAM_TABLE, 24'h0}, 32, 1'b0, 1'b0);
    tx(32'h0, 8, 1'b0, 1'b1);
    for (int i = 0; i < 25; i++) begin
      tx(32'h0, 8, 1'b0, 1'b1);
      `CHK("table_byte", tbl(8'(i)), r[7:0]);
    end
    `CHK("spi_read_oe", 4'h2, dev_oe);
    fr(1'b0);
    $display("test table done");
    w = 8'($random(seed));
    fr(1'b1);
    tx({24'h0, OP_SET_WRAP}, 8, 1'b0, 1'b0);
    tx({24'($random(seed)), w}, 32, 1'b0, 1'b0);
    fr(1'b0);
    `CHK("spi_wrap_cfg", w[6:4], wcb);
    `CHK("spi_wrap_bytes", wrap_of(w[6:5]), wby);
    {wl_set, su_set} = 2'b11;
    @(posedge i_clk);
    #1;
    {wl_set, su_set} = 2'b00;
    op(OP_QUAD_ENTER, 1'b0);
    `CHK("quad_no_permit", 0, quad);
    permit = 1'b1;
    op(OP_QUAD_ENTER, 1'b0);
    `CHK("quad_entered", 1, quad);
    `CHK("wrap_kept_in", wrap_of(w[6:5]), wby);
    `CHK("flags_kept_in", 2'b11, {wlf, suf});
    for (int i = 3; i >= 0; i--) begin
      p = 8'($random(seed));
      p[5:4] = 2'(i);
      p[1:0] = 2'(i);
      fr(1'b1);
      tx({16'h0, OP_READ_PARAM, p}, 16, 1'b1, 1'b0);
      fr(1'b0);
      `CHK("param_byte", p, rpb);
      `CHK("dummy_clocks", i == 0 ? 4 : i == 1 ? 6 : 8, dck);
      `CHK("wrap_bytes", wrap_of(2'(i)), wby);
    end
    $display("test params done");
    a = 24'($random(seed));
    a[2:0] = 3'h5;
    fr(1'b1);
    tx({OP_WRAP_READ, a}, 32, 1'b1, 1'b0);
    tx(32'h0, 16, 1'b1, 1'b1);
    for (int i = 0; i < 10; i++) begin
      tx(32'h0, 8, 1'b1, 1'b1);
      `CHK("wrap_byte", {a[7:3], 3'(a[2:0] + i)} ^ 8'hA5, r[7:0]);
    end
    fr(1'b0);
    p = 8'($random(seed));
    fr(1'b1);
    tx({OP_QUAD_IO_RD, a}, 32, 1'b1, 1'b0);
    tx({24'h0, p}, 8, 1'b1, 1'b0);
    tx(32'h0, 16, 1'b1, 1'b1);
    tx(32'h0, 8, 1'b1, 1'b1);
    `CHK("quad_io_byte", a[7:0] ^ 8'hA5, r[7:0]);
    fr(1'b0);
    `CHK("mode_bits", p, crb);
    $display("test quad read done");
    op(OP_QUAD_EXIT, 1'b1);
    `CHK("quad_left", 0, quad);
    `CHK("kept_out", {2'b11, 7'h08}, {wlf, suf, wby});
    op(OP_RST_ENABLE, 1'b0);
    op(8'h05, 1'b0);
    op(OP_RST_DO, 1'b0);
    `CHK("disarmed", 0, n_abort);
    op(OP_QUAD_ENTER, 1'b0);
    `CHK("busy_before", 0, busy);
    op(OP_RST_ENABLE, 1'b1);
    op(OP_RST_DO, 1'b1);
    `CHK("abort_seen", 1, n_abort);
    `CHK("cleared", 1, {quad, wlf, suf, rpb, crb, wcb, busy});
    op(OP_QUAD_ENTER, 1'b0);
    `CHK("busy_refuses", 0, quad);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge i_clk);
    `CHK("busy_ended", 0, busy);
    `CHK("busy_length", 1500, n_busy);
    $display("test reset done");
    report_and_stop();
  end
endmodule // serial_flash_quad_mode_reset_ctrl_tb
